/* dual_irq_map.vh */
// Address map, field positions and reset values of the interrupt logic
`ifndef DUAL_IRQ_MAP_VH
`define DUAL_IRQ_MAP_VH

// =====================================================================
// Register addresses on the device bus
`define ADDR_GATED_CONDITION_FLAGS      4'h2
`define ADDR_CMD_A     4'h2
`define ADDR_DATA_A    4'h3
`define ADDR_INPUT_CHANGE_REGISTER      4'h4
`define ADDR_FLAGS     4'h5
`define ADDR_CMD_B     4'hA
`define ADDR_DATA_B    4'hB
`define ADDR_VECTOR    4'hC
`define ADDR_CT_START  4'hE
`define ADDR_CT_STOP   4'hF

// =====================================================================
// Bit positions in the condition flags and the mask
`define BIT_TXR_A      0
`define BIT_RX_A       1
`define BIT_BRK_A      2
`define BIT_CTR        3
`define BIT_TXR_B      4
`define BIT_RX_B       5
`define BIT_BRK_B      6
`define BIT_INCHG      7

// =====================================================================
// Command codes in the upper nibble of a command write
`define CMD_FIELD_HI   7
`define CMD_FIELD_LO   4
`define CMD_RST_BRK    4'h5
`define CMD_SET_VECT   4'hC

// =====================================================================
// Reset values
`define MASK_RST       8'h00
`define VECTOR_RST     8'h0F
`define RDATA_RST      8'h00

`endif

/* chan_irq_flags.v */
// Per-channel transmit-ready, receive and break-change flags
`timescale 1ns/1ps
module chan_irq_flags (
   input  wire clock_i,
   input  wire nrst_i,
   input  wire tx_enable_i,
   input  wire thr_write_i,
   input  wire tx_taken_i,
   input  wire rx_push_i,
   input  wire rx_full_i,
   input  wire rx_nonempty_i,
   input  wire rx_pop_i,
   input  wire ffull_sel_i,
   input  wire brk_change_i,
   input  wire brk_clear_i,
   output reg  tx_ready_o,
   output reg  tx_send_o,
   output reg  rx_flag_o,
   output reg  brk_flag_o
);

   reg en_d;
   reg refill;
   reg next_ready;

   // Transmit-ready follows enable, writes and shifter loads
   always @* begin
      if (!tx_enable_i)
         next_ready = 1'b0;
      else if (!en_d)
         next_ready = 1'b1;
      else if (tx_taken_i)
         next_ready = 1'b1;
      else if (thr_write_i)
         next_ready = 1'b0;
      else
         next_ready = tx_ready_o;
   end

   // Held character goes out only while enabled
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_d       <= 1'b0;
         tx_ready_o <= 1'b0;
         tx_send_o  <= 1'b0;
      end else begin
         en_d       <= tx_enable_i;
         tx_ready_o <= next_ready;
         tx_send_o  <= tx_enable_i & en_d & ~next_ready;
      end
   end

   // Receive flag: ready or full function, set wins over pop
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_flag_o <= 1'b0;
         refill    <= 1'b0;
      end else begin
         refill <= rx_pop_i;
         if (rx_push_i && (!ffull_sel_i || rx_full_i))
            rx_flag_o <= 1'b1;
         else if (refill && !ffull_sel_i && rx_nonempty_i)
            rx_flag_o <= 1'b1;
         else if (rx_pop_i)
            rx_flag_o <= 1'b0;
      end
   end

   // Break-change flag, cleared only by its command
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         brk_flag_o <= 1'b0;
      else if (brk_change_i)
         brk_flag_o <= 1'b1;
      else if (brk_clear_i)
         brk_flag_o <= 1'b0;
   end

endmodule // chan_irq_flags

/* ctr_ready_flag.v */
// Counter/timer ready flag and stop handling
`timescale 1ns/1ps
module ctr_ready_flag (
   input  wire clock_i,
   input  wire nrst_i,
   input  wire timer_mode_i,
   input  wire period_tick_i,
   input  wire terminal_i,
   input  wire stop_cmd_i,
   output reg  flag_o,
   output reg  halt_o
);

   wire set_ev;

   // Period tick in timer mode, terminal count in counter mode
   assign set_ev = timer_mode_i ? period_tick_i : terminal_i;

   // Stop clears the flag; only counter mode halts the count
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_o <= 1'b0;
         halt_o <= 1'b0;
      end else begin
         halt_o <= stop_cmd_i & ~timer_mode_i;
         if (set_ev)
            flag_o <= 1'b1;
         else if (stop_cmd_i)
            flag_o <= 1'b0;
      end
   end

endmodule // ctr_ready_flag

/* dual_uart_interrupt_logic.v */
// Interrupt flags, mask, vector and acknowledge logic of a dual UART
`timescale 1ns/1ps
`include "dual_irq_map.vh"
module dual_uart_interrupt_logic (
   input  wire       clock_i,
   input  wire       nrst_i,
   input  wire [3:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       rd_i,
   input  wire       wr_i,
   input  wire       iack_i,
   input  wire       iei_i,
   input  wire       tx_enable_a_i,
   input  wire       tx_enable_b_i,
   input  wire       tx_taken_a_i,
   input  wire       tx_taken_b_i,
   input  wire       rx_push_a_i,
   input  wire       rx_push_b_i,
   input  wire       rx_full_a_i,
   input  wire       rx_full_b_i,
   input  wire       rx_nonempty_a_i,
   input  wire       rx_nonempty_b_i,
   input  wire       ffull_sel_a_i,
   input  wire       ffull_sel_b_i,
   input  wire       break_change_a_i,
   input  wire       break_change_b_i,
   input  wire       ct_timer_mode_i,
   input  wire       ct_period_tick_i,
   input  wire       ct_terminal_i,
   input  wire       input_change_i,
   output reg  [7:0] rdata_o,
   output reg        rdata_oe_o,
   output reg        irq_n_o,
   output reg        ieo_o,
   output reg        vectored_mode_o,
   output wire       tx_hold_empty_a_o,
   output wire       tx_hold_empty_b_o,
   output wire       tx_send_a_o,
   output wire       tx_send_b_o,
   output reg        rx_pop_a_o,
   output reg        rx_pop_b_o,
   output reg        ct_start_o,
   output wire       ct_halt_o
);

   // ==================================================================
   // Storage and decode
   reg  [7:0] interrupt_enable_mask;
   reg  [7:0] vector_byte_register;
   reg        inchg_flag;
   reg        iei_s1;
   reg        iei_s2;
   wire [7:0] interrupt_condition_flags;
   wire [7:0] gated_condition_flags;
   wire [1:0] tx_ready;
   wire [1:0] tx_send;
   wire [1:0] rx_flag;
   wire [1:0] brk_flag;
   wire [1:0] thr_wr;
   wire [1:0] pop;
   wire [1:0] brk_clr;
   wire [1:0] cmd_wr;
   wire       ctr_flag;
   wire       pending;

   // True when a write carries the given upper-nibble command
   function cmd_is;
      input [7:0] data;
      input [3:0] code;
      begin
         cmd_is = (data[`CMD_FIELD_HI:`CMD_FIELD_LO] == code);
      end
   endfunction

   // Per-channel strobes
   assign thr_wr  = {wr_i & (addr_i == `ADDR_DATA_B),
                     wr_i & (addr_i == `ADDR_DATA_A)};
   assign pop     = {rd_i & (addr_i == `ADDR_DATA_B),
                     rd_i & (addr_i == `ADDR_DATA_A)};
   assign cmd_wr  = {wr_i & (addr_i == `ADDR_CMD_B),
                     wr_i & (addr_i == `ADDR_CMD_A)};
   assign brk_clr = cmd_wr & {2{cmd_is(wdata_i, `CMD_RST_BRK)}};

   // ==================================================================
   // Channel flag blocks
   wire [1:0] tx_en_v = {tx_enable_b_i, tx_enable_a_i};
   wire [1:0] taken_v = {tx_taken_b_i, tx_taken_a_i};
   wire [1:0] push_v  = {rx_push_b_i, rx_push_a_i};
   wire [1:0] full_v  = {rx_full_b_i, rx_full_a_i};
   wire [1:0] nemp_v  = {rx_nonempty_b_i, rx_nonempty_a_i};
   wire [1:0] fsel_v  = {ffull_sel_b_i, ffull_sel_a_i};
   wire [1:0] bchg_v  = {break_change_b_i, break_change_a_i};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         chan_irq_flags u_chan (
            .clock_i       (clock_i),
            .nrst_i        (nrst_i),
            .tx_enable_i   (tx_en_v[ch]),
            .thr_write_i   (thr_wr[ch]),
            .tx_taken_i    (taken_v[ch]),
            .rx_push_i     (push_v[ch]),
            .rx_full_i     (full_v[ch]),
            .rx_nonempty_i (nemp_v[ch]),
            .rx_pop_i      (pop[ch]),
            .ffull_sel_i   (fsel_v[ch]),
            .brk_change_i  (bchg_v[ch]),
            .brk_clear_i   (brk_clr[ch]),
            .tx_ready_o    (tx_ready[ch]),
            .tx_send_o     (tx_send[ch]),
            .rx_flag_o     (rx_flag[ch]),
            .brk_flag_o    (brk_flag[ch])
         );
      end
   endgenerate

   assign tx_hold_empty_a_o = tx_ready[0];
   assign tx_hold_empty_b_o = tx_ready[1];
   assign tx_send_a_o       = tx_send[0];
   assign tx_send_b_o       = tx_send[1];

   // ==================================================================
   // Counter/timer ready
   ctr_ready_flag u_ctr (
      .clock_i       (clock_i),
      .nrst_i        (nrst_i),
      .timer_mode_i  (ct_timer_mode_i),
      .period_tick_i (ct_period_tick_i),
      .terminal_i    (ct_terminal_i),
      .stop_cmd_i    (rd_i & (addr_i == `ADDR_CT_STOP)),
      .flag_o        (ctr_flag),
      .halt_o        (ct_halt_o)
   );

   // ==================================================================
   // Flag assembly; raw flags independent of the mask, gated flags and pending masked
   assign interrupt_condition_flags = {
      inchg_flag, brk_flag[1], rx_flag[1], tx_ready[1],
      ctr_flag,   brk_flag[0], rx_flag[0], tx_ready[0]};
   assign gated_condition_flags =
      interrupt_condition_flags & interrupt_enable_mask;
   assign pending = |gated_condition_flags;

   // Input-change flag, set wins over the read clear
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         inchg_flag <= 1'b0;
      else if (input_change_i)
         inchg_flag <= 1'b1;
      else if (rd_i && addr_i == `ADDR_INPUT_CHANGE_REGISTER)
         inchg_flag <= 1'b0;
   end

   // ==================================================================
   // Mask, vector byte and mode
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         interrupt_enable_mask <= `MASK_RST;
         vector_byte_register  <= `VECTOR_RST;
         vectored_mode_o       <= 1'b0;
      end else begin
         if (wr_i && addr_i == `ADDR_FLAGS)
            interrupt_enable_mask <= wdata_i;
         if (wr_i && addr_i == `ADDR_VECTOR)
            vector_byte_register <= wdata_i;
         if (|cmd_wr && cmd_is(wdata_i, `CMD_SET_VECT))
            vectored_mode_o <= 1'b1;
      end
   end

   // ==================================================================
   // Daisy-chain enable input, two-stage synchroniser
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         iei_s1 <= 1'b0;
         iei_s2 <= 1'b0;
      end else begin
         iei_s1 <= iei_i;
         iei_s2 <= iei_s1;
      end
   end

   // Request and chain outputs
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_n_o <= 1'b1;
         ieo_o   <= 1'b0;
      end else begin
         irq_n_o <= ~pending;
         ieo_o   <= iei_s2 & ~(vectored_mode_o & pending);
      end
   end

   // ==================================================================
   // Read data, acknowledge answer and address-triggered strobes
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o    <= `RDATA_RST;
         rdata_oe_o <= 1'b0;
         rx_pop_a_o <= 1'b0;
         rx_pop_b_o <= 1'b0;
         ct_start_o <= 1'b0;
      end else begin
         rx_pop_a_o <= pop[0];
         rx_pop_b_o <= pop[1];
         ct_start_o <= rd_i & (addr_i == `ADDR_CT_START);
         rdata_oe_o <= 1'b0;
         rdata_o    <= `RDATA_RST;
         if (iack_i) begin
            if (vectored_mode_o && iei_s2 && pending) begin
               rdata_o    <= vector_byte_register;
               rdata_oe_o <= 1'b1;
            end
         end else if (rd_i) begin
            case (addr_i)
               `ADDR_FLAGS: begin
                  rdata_o    <= interrupt_condition_flags;
                  rdata_oe_o <= 1'b1;
               end
               `ADDR_GATED_CONDITION_FLAGS: begin
                  rdata_o    <= gated_condition_flags;
                  rdata_oe_o <= 1'b1;
               end
               `ADDR_VECTOR: begin
                  rdata_o    <= vector_byte_register;
                  rdata_oe_o <= 1'b1;
               end
               default: begin
                  rdata_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // dual_uart_interrupt_logic

/* dual_uart_interrupt_logic_monitor.sv */
// Checker of the interrupt logic port behaviour
`timescale 1ns/1ps
module dual_uart_interrupt_logic_monitor (
   input wire       clock_i,
   input wire       nrst_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       rd_i,
   input wire       wr_i,
   input wire       iack_i,
   input wire       tx_enable_a_i,
   input wire       tx_taken_a_i,
   input wire       ct_timer_mode_i,
   input wire       rdata_oe_o,
   input wire       irq_n_o,
   input wire       vectored_mode_o,
   input wire       tx_hold_empty_a_o,
   input wire       tx_send_a_o,
   input wire       ct_halt_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // =====================================================================
   // Decoded accesses
   wire rd_ok   = rd_i && !iack_i;
   wire set_cmd = wr_i && wdata_i[7:4] == 4'hC && (addr_i == 4'h2 || addr_i == 4'hA);
   wire stop_rd = rd_ok && addr_i == 4'hF;

   property p_tx_on;
      $rose(tx_enable_a_i) |=> tx_hold_empty_a_o;
   endproperty
   a_tx_on: assert property (p_tx_on) else $error("ready not set on enable");
   property p_tx_off;
      !tx_enable_a_i |=> !tx_hold_empty_a_o && !tx_send_a_o;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("ready or send while off");
   property p_tx_clear;
      wr_i && addr_i == 4'h3 && tx_enable_a_i && $past(tx_enable_a_i) && !tx_taken_a_i |=> !tx_hold_empty_a_o;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("ready kept on write");
   property p_mask_off;
      wr_i && addr_i == 4'h5 && wdata_i == 8'h00 |=> ##1 irq_n_o;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("request with mask zero");
   property p_vec_cmd;
      $rose(vectored_mode_o) |-> $past(set_cmd);
   endproperty
   a_vec_cmd: assert property (p_vec_cmd) else $error("vectored without command");
   property p_iack_quiet;
      iack_i && !vectored_mode_o |=> !rdata_oe_o;
   endproperty
   a_iack_quiet: assert property (p_iack_quiet) else $error("vector in plain mode");
   property p_gated_read;
      rd_ok && addr_i == 4'h2 |=> rdata_oe_o;
   endproperty
   a_gated_read: assert property (p_gated_read) else $error("gated read unanswered");
   property p_ctr_stop;
      stop_rd && !ct_timer_mode_i |-> ##[1:2] ct_halt_o;
   endproperty
   a_ctr_stop: assert property (p_ctr_stop) else $error("counter not halted");
   property p_timer_run;
      stop_rd && ct_timer_mode_i ##1 ct_timer_mode_i |-> !ct_halt_o ##1 !ct_halt_o;
   endproperty
   a_timer_run: assert property (p_timer_run) else $error("timer halted");
endmodule // dual_uart_interrupt_logic_monitor

bind dual_uart_interrupt_logic dual_uart_interrupt_logic_monitor mon (
   .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .rd_i(rd_i), .wr_i(wr_i), .iack_i(iack_i), .tx_enable_a_i(tx_enable_a_i),
   .tx_taken_a_i(tx_taken_a_i), .ct_timer_mode_i(ct_timer_mode_i),
   .rdata_oe_o(rdata_oe_o), .irq_n_o(irq_n_o),
   .vectored_mode_o(vectored_mode_o), .tx_send_a_o(tx_send_a_o),
   .tx_hold_empty_a_o(tx_hold_empty_a_o), .ct_halt_o(ct_halt_o));

/* host_bus_model.sv */
// Host processor model issuing register and acknowledge cycles
`timescale 1ns/1ps
module host_bus_model (
   input  wire       clock_i,
   input  wire [7:0] rdata_i,
   input  wire       rdata_oe_i,
   output reg  [3:0] addr_o,
   output reg  [7:0] wdata_o,
   output reg        rd_o,
   output reg        wr_o,
   output reg        iack_o,
   output reg        iei_o
);
   // Idle bus, chain enabled upstream
   initial begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
      wr_o = 1'b0;
      iack_o = 1'b0;
      iei_o = 1'b1;
   end
   // One cycle strobe, lines inverted once released
   task cycle(input [3:0] a, input [7:0] d, input w, input r, input k,
              output [7:0] q, output oe);
      begin
         @(posedge clock_i);
         #1;
         addr_o = a;
         wdata_o = d;
         wr_o = w;
         rd_o = r;
         iack_o = k;
         @(posedge clock_i);
         #1;
         {wr_o, rd_o, iack_o} = 3'b000;
         addr_o = ~a;
         wdata_o = ~d;
         q = rdata_i;
         oe = rdata_oe_i;
      end
   endtask
   task wr_reg(input [3:0] a, input [7:0] d);
      reg [7:0] q;
      reg       oe;
      cycle(a, d, 1'b1, 1'b0, 1'b0, q, oe);
   endtask
   task rd_reg(input [3:0] a, output [7:0] q, output oe);
      cycle(a, 8'h00, 1'b0, 1'b1, 1'b0, q, oe);
   endtask
   task ack(output [7:0] q, output oe);
      cycle(4'h0, 8'h00, 1'b0, 1'b0, 1'b1, q, oe);
   endtask
   task enable_all;
      wr_reg(4'h5, 8'hFF);
   endtask
endmodule // host_bus_model

/* dual_uart_interrupt_logic_test.sv */
// Self-checking bench of the interrupt logic
`timescale 1ns/1ps
`include "dual_irq_map.vh"
module dual_uart_interrupt_logic_test;
   reg        clock_i, nrst_i, ten_a, ten_b, tkn_a, psh_a, ful_a, ne_a, sel_a;
   reg        brk_a, brk_b, tmode, tick, term, chg, k;
   reg  [7:0] fl, d;
   wire [3:0] addr;
   wire [7:0] wdata, rdata;
   wire       rd, wr, iack, iei, oe, irq_n, ieo, vect, txe_a, txe_b, snd_a;
   wire       pop_a, cst, hlt;
   int        failures, samples_checked;
   host_bus_model host (.clock_i(clock_i), .rdata_i(rdata), .rdata_oe_i(oe),
      .addr_o(addr), .wdata_o(wdata), .rd_o(rd), .wr_o(wr), .iack_o(iack),
      .iei_o(iei));
   dual_uart_interrupt_logic DUT (.clock_i(clock_i), .nrst_i(nrst_i),
      .addr_i(addr), .wdata_i(wdata), .rd_i(rd), .wr_i(wr), .iack_i(iack),
      .iei_i(iei), .tx_enable_a_i(ten_a), .tx_enable_b_i(ten_b),
      .tx_taken_a_i(tkn_a), .tx_taken_b_i(1'b0), .rx_push_a_i(psh_a),
      .rx_push_b_i(1'b0), .rx_full_a_i(ful_a), .rx_full_b_i(1'b0),
      .rx_nonempty_a_i(ne_a), .rx_nonempty_b_i(1'b0), .ffull_sel_a_i(sel_a),
      .ffull_sel_b_i(1'b0), .break_change_a_i(brk_a), .break_change_b_i(brk_b),
      .ct_timer_mode_i(tmode), .ct_period_tick_i(tick), .ct_terminal_i(term),
      .input_change_i(chg), .rdata_o(rdata), .rdata_oe_o(oe), .irq_n_o(irq_n),
      .ieo_o(ieo), .vectored_mode_o(vect), .tx_hold_empty_a_o(txe_a),
      .tx_hold_empty_b_o(txe_b), .tx_send_a_o(snd_a), .tx_send_b_o(),
      .rx_pop_a_o(pop_a), .rx_pop_b_o(), .ct_start_o(cst), .ct_halt_o(hlt));
   // =====================================================================
   // Helpers
   task chk(input string n, input [7:0] got, input [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0s expected %h seen %h", n, exp, got);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task rf;
      host.rd_reg(`ADDR_FLAGS, fl, k);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // =====================================================================
   // Scenarios
   task t_reset;
      chk("irq_n", irq_n, 1);
      chk("vectored", vect, 0);
      rf;
      chk("flags", fl, 0);
      host.wr_reg(`ADDR_FLAGS, 8'h00);
      cyc(2);
      chk("irq_n masked", irq_n, 1);
      $display("reset test done");
   endtask
   task t_tx;
      host.wr_reg(`ADDR_DATA_A, 8'h41);
      ten_a = 1;
      ten_b = 1;
      cyc(2);
      chk("send off", snd_a, 0);
      chk("ready a", txe_a, 1);
      rf;
      chk("tx bits", fl & 8'h11, 8'h11);
      host.wr_reg(`ADDR_DATA_A, 8'h42);
      cyc(1);
      chk("ready a", txe_a, 0);
      chk("send on", snd_a, 1);
      rf;
      chk("tx bit a", fl[0], 0);
      tkn_a = 1;
      cyc(1);
      tkn_a = 0;
      rf;
      chk("tx bit a", fl[0], 1);
      ten_b = 0;
      cyc(2);
      chk("ready b", txe_b, 0);
      ten_b = 1;
      cyc(2);
      $display("transmit test done");
   endtask
   task t_mask;
      rf;
      chk("raw flags", fl, 8'h11);
      host.rd_reg(`ADDR_GATED_CONDITION_FLAGS, d, k);
      chk("gated", d, 8'h00);
      host.enable_all;
      cyc(2);
      chk("irq_n", irq_n, 0);
      rf;
      chk("flags not mask", fl, 8'h11);
      host.wr_reg(`ADDR_FLAGS, 8'h10);
      host.rd_reg(`ADDR_GATED_CONDITION_FLAGS, d, k);
      chk("gated", d, 8'h10);
      host.wr_reg(`ADDR_FLAGS, 8'hEE);
      cyc(2);
      chk("irq_n", irq_n, 1);
      host.enable_all;
      $display("mask test done");
   endtask
   task t_rx;
      ne_a = 1;
      psh_a = 1;
      cyc(1);
      psh_a = 0;
      rf;
      chk("rx ready", fl[1], 1);
      host.rd_reg(`ADDR_DATA_A, d, k);
      chk("pop a", pop_a, 1);
      cyc(3);
      rf;
      chk("rx refill", fl[1], 1);
      ne_a = 0;
      host.rd_reg(`ADDR_DATA_A, d, k);
      cyc(3);
      rf;
      chk("rx empty", fl[1], 0);
      sel_a = 1;
      ne_a = 1;
      psh_a = 1;
      cyc(1);
      ful_a = 1;
      cyc(1);
      psh_a = 0;
      rf;
      chk("rx full", fl[1], 1);
      ful_a = 0;
      host.rd_reg(`ADDR_DATA_A, d, k);
      cyc(3);
      rf;
      chk("no refill", fl[1], 0);
      $display("receive test done");
   endtask
   task t_misc;
      brk_a = 1;
      cyc(1);
      brk_a = 0;
      host.wr_reg(`ADDR_CMD_B, {`CMD_RST_BRK, 4'h0});
      rf;
      chk("break a", fl[2], 1);
      host.wr_reg(`ADDR_CMD_A, {`CMD_RST_BRK, 4'h0});
      brk_b = 1;
      cyc(1);
      brk_b = 0;
      rf;
      chk("breaks", fl & 8'h44, 8'h40);
      host.wr_reg(`ADDR_CMD_B, {`CMD_RST_BRK, 4'h0});
      tmode = 1;
      tick = 1;
      chg = 1;
      cyc(1);
      tick = 0;
      chg = 0;
      rf;
      chk("set", fl & 8'hC8, 8'h88);
      host.rd_reg(`ADDR_CT_STOP, d, k);
      host.rd_reg(`ADDR_INPUT_CHANGE_REGISTER, d, k);
      rf;
      chk("cleared", fl & 8'hC8, 8'h00);
      tmode = 0;
      term = 1;
      cyc(1);
      term = 0;
      rf;
      chk("counter", fl[3], 1);
      host.rd_reg(`ADDR_CT_STOP, d, k);
      chk("halt", hlt, 1);
      rf;
      chk("counter", fl[3], 0);
      host.rd_reg(`ADDR_CT_START, d, k);
      chk("start", cst, 1);
      chk("start oe", k, 0);
      $display("event test done");
   endtask
   task t_vec;
      host.wr_reg(`ADDR_VECTOR, 8'h5A);
      host.rd_reg(`ADDR_VECTOR, d, k);
      chk("vector", d, 8'h5A);
      host.ack(d, k);
      chk("no vector", k, 0);
      chk("chain pass", ieo, 1);
      host.wr_reg(`ADDR_CMD_A, {`CMD_SET_VECT, 4'h0});
      cyc(1);
      chk("vectored", vect, 1);
      host.ack(d, k);
      chk("vector oe", k, 1);
      chk("vector", d, 8'h5A);
      chk("chain out", ieo, 0);
      $display("vector test done");
   endtask
   // Clock
   initial begin
      clock_i = 0;
      forever #2.5 clock_i = ~clock_i;
   end
   // Watchdog
   initial begin
      #20000;
      failures++;
      complete_run;
   end
   // Main sequence
   initial begin
      {nrst_i, ten_a, ten_b, tkn_a, psh_a, ful_a, ne_a, sel_a} = 8'h00;
      {brk_a, brk_b, tmode, tick, term, chg} = 6'h00;
      failures = 0;
      samples_checked = 0;
      repeat (8) @(posedge clock_i);
      #1;
      nrst_i = 1;
      t_reset;
      t_tx;
      t_mask;
      t_rx;
      t_misc;
      t_vec;
      complete_run;
   end
endmodule // dual_uart_interrupt_logic_test
